/* verilog/acp_top.sv */
/*
 anemometer command parameter block: holds the serial command parameters
 behind an AXI4-Lite slave and acts on them.
 assumes a telegram parser outside writes each parsed parameter to its
 register; one clock, synchronous reset.
*/
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module acp_top
	import acp_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sample_valid,
	input wire logic [15:0] sample,
	input wire logic state_proto_on,
	output logic termination_on,
	output acp_line_t line_cfg,
	output logic [15:0] mean_period,
	output logic [15:0] pretrigger_ms,
	output logic [15:0] capture_depth_q
);
	typedef enum logic [1:0] {
		ACP_W_IDLE = 2'b00,
		ACP_W_RESP = 2'b01
	} acp_wstate_t;
	typedef struct packed {
		acp_wstate_t wst;
		logic aw_ok;
		logic w_ok;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [1:0] bresp;
		logic bvalid;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [15:0] mean_window_cmd;
		logic [15:0] out_interval;
		logic [15:0] scale_low_chan_a;
		logic [15:0] scale_high_chan_a;
		logic [2:0] state_addr_set;
		logic [15:0] pretrigger_time;
		logic [6:0] line_rate_code;
		logic [6:0] committed_rate;
		logic fast_pending;
		logic [6:0] fast_line_rate_code;
		logic [15:0] capture_depth;
		logic line_termination_on;
		logic access_key_cmd;
		logic [15:0] period;
		logic [31:0] tick_cnt;
		logic tick;
		logic restart;
		acp_line_t line;
	} acp_state_t;
	acp_state_t s_q, s_d;
	acp_line_t line_dec;
	acp_addrs_t addrs;
	logic [15:0] mean_val;
	logic [4:0] mean_cnt;
	logic [15:0] wval;
	logic wr_fire;
	acp_rate_decode u_rate (
		.code(s_q.line_rate_code),
		.line(line_dec)
	);
	acp_mean_buffer u_mean (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.tick(s_q.tick),
		.window(s_q.period),
		.sample_valid(sample_valid),
		.sample(sample),
		.mean_q(mean_val),
		.count_q(mean_cnt)
	);
	function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction
	// averaging code to period in 100 ms units
	function automatic logic [15:0] avg_period(input logic [15:0] code,
		input logic [15:0] out_int);
		unique case (code)
			16'h0000: avg_period = out_int / 16'h0064;
			16'h0001: avg_period = 16'h000A;
			16'h0002: avg_period = 16'h0064;
			16'h0003: avg_period = 16'h0258;
			16'h0004: avg_period = 16'h04B0;
			16'h0005: avg_period = 16'h1770;
			default: avg_period = code;
		endcase
	endfunction
	always_comb begin
		s_d = s_q;
		addrs = acp_addr_lookup(s_q.state_addr_set);
		wval = s_q.wdata[15:0];
		wr_fire = 1'b0;
		s_d.tick = 1'b0;
		s_d.restart = 1'b0;
		s_d.tick_cnt = s_q.tick_cnt + 32'h1;
		if (s_q.tick_cnt == 32'(ACP_TICK_CYC - 1)) begin
			s_d.tick_cnt = 32'h0;
			s_d.tick = 1'b1;
		end
		s_d.period = avg_period(s_q.mean_window_cmd, s_q.out_interval);
		s_d.line = line_dec;
		// write channel: address and data in either order
		if (s_axi_awvalid && !s_q.aw_ok && s_q.wst == ACP_W_IDLE) begin
			s_d.aw_ok = 1'b1;
			s_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_q.w_ok && s_q.wst == ACP_W_IDLE) begin
			s_d.w_ok = 1'b1;
			s_d.wdata = s_axi_wdata;
		end
		unique case (s_q.wst)
			ACP_W_IDLE: begin
				if (s_q.aw_ok && s_q.w_ok) begin
					wr_fire = 1'b1;
					s_d.aw_ok = 1'b0;
					s_d.w_ok = 1'b0;
					s_d.bvalid = 1'b1;
					s_d.bresp = 2'b00;
					s_d.wst = ACP_W_RESP;
				end
			end
			ACP_W_RESP: begin
				if (s_axi_bready) begin
					s_d.bvalid = 1'b0;
					s_d.wst = ACP_W_IDLE;
				end
			end
		endcase
		if (wr_fire) begin
			// out of range values leave the setting alone, answered SLVERR
			unique case (s_q.awaddr)
				ACP_OFS_MEAN:
					if (wval <= ACP_MEAN_MAX) s_d.mean_window_cmd = wval;
					else s_d.bresp = 2'b10;
				ACP_OFS_OUT_INT: s_d.out_interval = wval;
				ACP_OFS_SCL_LO: s_d.scale_low_chan_a = wval;
				ACP_OFS_SCL_HI: s_d.scale_high_chan_a = wval;
				ACP_OFS_ADDR_SET:
					if (wval <= ACP_ADDR_SET_MAX) s_d.state_addr_set = wval[2:0];
					else s_d.bresp = 2'b10;
				ACP_OFS_PRETRIG: s_d.pretrigger_time = wval;
				ACP_OFS_RATE:
					if (in_range(wval, ACP_RATE_MIN, ACP_RATE_MAX)) begin
						s_d.line_rate_code = wval[6:0];
						s_d.committed_rate = wval[6:0];
						s_d.fast_pending = 1'b0;
					end else s_d.bresp = 2'b10;
				ACP_OFS_DEPTH:
					if (in_range(wval, 16'h0001, ACP_DEPTH_MAX)) s_d.capture_depth = wval;
					else s_d.bresp = 2'b10;
				ACP_OFS_TERM:
					if (wval <= 16'h0001) s_d.line_termination_on = wval[0];
					else s_d.bresp = 2'b10;
				ACP_OFS_FAST:
					// temporary on first, committed on identical repeat
					if (in_range(wval, ACP_FAST_MIN, ACP_FAST_MAX) && s_q.access_key_cmd) begin
						if (s_q.fast_pending && s_q.fast_line_rate_code == wval[6:0]) begin
							s_d.committed_rate = wval[6:0];
							s_d.fast_pending = 1'b0;
						end else begin
							s_d.fast_pending = 1'b1;
							s_d.fast_line_rate_code = wval[6:0];
						end
						s_d.line_rate_code = wval[6:0];
					end else s_d.bresp = 2'b10;
				ACP_OFS_KEY: s_d.access_key_cmd = wval[0];
				ACP_OFS_RESTART:
					if (wval[0]) begin
						// soft restart: uncommitted rate is dropped
						s_d.line_rate_code = s_q.committed_rate;
						s_d.fast_pending = 1'b0;
						s_d.restart = 1'b1;
					end
				default: s_d.bresp = 2'b10;
			endcase
		end
		// read channel
		if (s_q.rvalid) begin
			if (s_axi_rready)
				s_d.rvalid = 1'b0;
		end else if (s_axi_arvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = 2'b00;
			s_d.rdata = 32'h0;
			unique case (s_axi_araddr)
				ACP_OFS_MEAN: s_d.rdata = {16'h0, s_q.mean_window_cmd};
				ACP_OFS_OUT_INT: s_d.rdata = {16'h0, s_q.out_interval};
				ACP_OFS_SCL_LO: s_d.rdata = {16'h0, s_q.scale_low_chan_a};
				ACP_OFS_SCL_HI: s_d.rdata = {16'h0, s_q.scale_high_chan_a};
				ACP_OFS_ADDR_SET: s_d.rdata = {29'h0, s_q.state_addr_set};
				ACP_OFS_LOADER: s_d.rdata = {16'h0, ACP_LOADER_VER};
				ACP_OFS_PRETRIG: s_d.rdata = {16'h0, s_q.pretrigger_time};
				ACP_OFS_RATE, ACP_OFS_FAST: s_d.rdata = {25'h0, s_q.line_rate_code};
				ACP_OFS_DEPTH: s_d.rdata = {16'h0, s_q.capture_depth};
				ACP_OFS_TERM: s_d.rdata = {31'h0, s_q.line_termination_on};
				ACP_OFS_STAT: s_d.rdata = {22'h0, mean_cnt, s_q.fast_pending,
					1'b0, s_q.access_key_cmd, 1'b0, state_proto_on};
				ACP_OFS_ADDRS:
					if (state_proto_on) s_d.rdata = {addrs.vtemp[7:0], addrs.dir, addrs.speed};
				ACP_OFS_MEAN_PER: s_d.rdata = {16'h0, s_q.period};
				ACP_OFS_SAMPLE: s_d.rdata = {25'h0, s_q.committed_rate};
				ACP_OFS_MEAN_OUT: s_d.rdata = {16'h0, mean_val};
				ACP_OFS_KEY: s_d.rdata = {31'h0, s_q.access_key_cmd};
				ACP_OFS_RESTART: s_d.rdata = 32'h0;
				default: s_d.rresp = 2'b10;
			endcase
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			s_q <= '0;
			s_q.wst <= ACP_W_IDLE;
			s_q.mean_window_cmd <= ACP_RST_MEAN;
			s_q.out_interval <= ACP_RST_OUT_INT;
			s_q.scale_low_chan_a <= ACP_RST_SCALE;
			s_q.scale_high_chan_a <= ACP_RST_SCALE;
			s_q.pretrigger_time <= ACP_RST_PRETRIG;
			s_q.line_rate_code <= ACP_RST_RATE;
			s_q.committed_rate <= ACP_RST_RATE;
			s_q.capture_depth <= ACP_RST_DEPTH;
			s_q.period <= ACP_RST_MEAN;
		end else begin
			s_q <= s_d;
		end
	end
	// outputs straight from state flops
	assign s_axi_awready = !s_q.aw_ok && s_q.wst == ACP_W_IDLE;
	assign s_axi_wready = !s_q.w_ok && s_q.wst == ACP_W_IDLE;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign termination_on = s_q.line_termination_on;
	assign line_cfg = s_q.line;
	assign mean_period = s_q.period;
	assign pretrigger_ms = s_q.pretrigger_time;
	assign capture_depth_q = s_q.capture_depth;
endmodule

/* verilog/acp_pkg.sv */
/*
 package for the anemometer command parameter block: register map,
 reset values, ranges, the address lookup table and shared types.
 assumes nothing of its surroundings.
*/
package acp_pkg;
	// register byte offsets
	localparam logic [7:0] ACP_OFS_MEAN = 8'h00;
	localparam logic [7:0] ACP_OFS_OUT_INT = 8'h04;
	localparam logic [7:0] ACP_OFS_SCL_LO = 8'h08;
	localparam logic [7:0] ACP_OFS_SCL_HI = 8'h0C;
	localparam logic [7:0] ACP_OFS_ADDR_SET = 8'h10;
	localparam logic [7:0] ACP_OFS_LOADER = 8'h14;
	localparam logic [7:0] ACP_OFS_PRETRIG = 8'h18;
	localparam logic [7:0] ACP_OFS_RATE = 8'h1C;
	localparam logic [7:0] ACP_OFS_DEPTH = 8'h20;
	localparam logic [7:0] ACP_OFS_TERM = 8'h24;
	localparam logic [7:0] ACP_OFS_FAST = 8'h28;
	localparam logic [7:0] ACP_OFS_STAT = 8'h2C;
	localparam logic [7:0] ACP_OFS_ADDRS = 8'h30;
	localparam logic [7:0] ACP_OFS_MEAN_PER = 8'h34;
	localparam logic [7:0] ACP_OFS_SAMPLE = 8'h38;
	localparam logic [7:0] ACP_OFS_MEAN_OUT = 8'h3C;
	localparam logic [7:0] ACP_OFS_KEY = 8'h40;
	localparam logic [7:0] ACP_OFS_RESTART = 8'h44;
	// reset values
	localparam logic [15:0] ACP_RST_MEAN = 16'h000A;
	localparam logic [15:0] ACP_RST_OUT_INT = 16'h03E8;
	localparam logic [15:0] ACP_RST_SCALE = 16'h7530;
	localparam logic [15:0] ACP_RST_PRETRIG = 16'h0064;
	localparam logic [6:0] ACP_RST_RATE = 7'h05;
	localparam logic [15:0] ACP_RST_DEPTH = 16'h03E8;
	// ranges
	localparam logic [15:0] ACP_MEAN_MAX = 16'hEA60;
	localparam logic [15:0] ACP_ADDR_SET_MAX = 16'h0005;
	localparam logic [15:0] ACP_RATE_MIN = 16'h0002;
	localparam logic [15:0] ACP_RATE_MAX = 16'h0031;
	localparam logic [15:0] ACP_FAST_MIN = 16'h0065;
	localparam logic [15:0] ACP_FAST_MAX = 16'h0067;
	localparam logic [15:0] ACP_DEPTH_MAX = 16'h9C40;
	// loader version, value arbitrary
	localparam logic [15:0] ACP_LOADER_VER = 16'h012C;
	// 100 ms tick at 200 MHz
	localparam int ACP_CLK_MHZ = 200;
	localparam int ACP_TICK_MS = 100;
	localparam int ACP_TICK_CYC = ACP_TICK_MS * 1000 * ACP_CLK_MHZ;
	localparam int ACP_BUF_DEPTH = 16;
	localparam int ACP_BUF_AW = 4;
	// framing groups
	typedef enum logic [2:0] {
		ACP_F_8N1 = 3'h0, ACP_F_7E1 = 3'h1, ACP_F_7O1 = 3'h2,
		ACP_F_8N2 = 3'h3, ACP_F_7E2 = 3'h4, ACP_F_7O2 = 3'h5
	} acp_frame_t;
	typedef struct packed {
		logic [19:0] baud;
		logic [2:0] frame;
	} acp_line_t;
	typedef struct packed {
		logic [11:0] speed;
		logic [11:0] dir;
		logic [11:0] vtemp;
	} acp_addrs_t;
	// fixed instrument address table, BCD per digit
	function automatic acp_addrs_t acp_addr_lookup(input logic [2:0] sel);
		unique case (sel)
			3'h0: acp_addr_lookup = '{12'h011, 12'h001, 12'h022};
			3'h1: acp_addr_lookup = '{12'h400, 12'h410, 12'h420};
			3'h2: acp_addr_lookup = '{12'h202, 12'h201, 12'h211};
			3'h3: acp_addr_lookup = '{12'h011, 12'h001, 12'h021};
			3'h4: acp_addr_lookup = '{12'h081, 12'h082, 12'h083};
			default: acp_addr_lookup = '{12'h001, 12'h002, 12'h003};
		endcase
	endfunction
endpackage

/* verilog/acp_rate_decode.sv */
/*
 decodes a line rate code (standard or extended) into baud and framing.
 assumes the code was range checked before it got here.
*/
`timescale 1ns/10ps
module acp_rate_decode
	import acp_pkg::*;
(
	input wire logic [6:0] code,
	output acp_line_t line
);
	logic [2:0] col;
	logic [6:0] rel;
	always_comb begin
		rel = code - 7'h02;
		col = rel[2:0];
		line.frame = rel[5:3];
		unique case (col)
			3'h0: line.baud = 20'h004B0;
			3'h1: line.baud = 20'h00960;
			3'h2: line.baud = 20'h012C0;
			3'h3: line.baud = 20'h02580;
			3'h4: line.baud = 20'h04B00;
			3'h5: line.baud = 20'h09600;
			3'h6: line.baud = 20'h0E100;
			default: line.baud = 20'h1C200;
		endcase
		if (code == 7'h65) begin
			line.baud = 20'h38400;
			line.frame = ACP_F_8N1;
		end else if (code == 7'h66) begin
			line.baud = 20'h70800;
			line.frame = ACP_F_8N1;
		end else if (code == 7'h67) begin
			line.baud = 20'hE1000;
			line.frame = ACP_F_8N1;
		end
	end
endmodule

/* verilog/acp_mean_buffer.sv */
/*
 sliding mean buffer: time stamped samples, entries older than the window
 are dropped, the mean covers whatever is held.
 assumes sample_valid pulses one cycle and tick is a 100 ms pulse.
*/
`timescale 1ns/10ps
module acp_mean_buffer
	import acp_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic tick,
	input wire logic [15:0] window,
	input wire logic sample_valid,
	input wire logic [15:0] sample,
	output logic [15:0] mean_q,
	output logic [4:0] count_q
);
	typedef struct packed {
		logic [ACP_BUF_DEPTH-1:0][15:0] val;
		logic [ACP_BUF_DEPTH-1:0][31:0] stamp;
		logic [ACP_BUF_AW-1:0] head;
		logic [4:0] count;
		logic [31:0] now;
		logic [15:0] mean;
	} acp_mb_t;
	acp_mb_t s_q, s_d;
	logic [ACP_BUF_AW-1:0] tail;
	logic [35:0] sum;
	logic [4:0] n;
	always_comb begin
		s_d = s_q;
		tail = s_q.head - s_q.count[ACP_BUF_AW-1:0];
		if (tick)
			s_d.now = s_q.now + 32'h1;
		// drop the oldest expired entry, one per cycle is plenty at 100 ms
		if (s_q.count != 5'h0 && (s_q.now - s_q.stamp[tail]) >= {16'h0, window})
			s_d.count = s_q.count - 5'h1;
		if (sample_valid) begin
			s_d.val[s_q.head] = sample;
			s_d.stamp[s_q.head] = s_q.now;
			s_d.head = s_q.head + 1'b1;
			if (s_d.count != 5'(ACP_BUF_DEPTH))
				s_d.count = s_d.count + 5'h1;
		end
		// average at once over what is held, no fill wait
		sum = 36'h0;
		n = 5'h0;
		for (int i = 0; i < ACP_BUF_DEPTH; i++) begin
			if (5'(i) < s_q.count) begin
				sum = sum + 36'(s_q.val[4'(s_q.head - 4'(i) - 4'h1)]);
				n = n + 5'h1;
			end
		end
		if (n != 5'h0)
			s_d.mean = 16'(sum / 36'(n));
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_b)
			s_q <= '0;
		else
			s_q <= s_d;
	end
	assign mean_q = s_q.mean;
	assign count_q = s_q.count;
endmodule

/* bench/acp_properties.sv */
/*
 checker for acp_top: bus answer timing and held settings.
 assumes it is bound to acp_top, one clock, synchronous reset.
*/
`timescale 1ns/10ps
module acp_properties
	import acp_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic termination_on,
	input wire acp_line_t line_cfg,
	input wire logic [15:0] pretrigger_ms,
	input wire logic [15:0] capture_depth_q
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	a_busy_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	// the address table read fills all 32 bits while state_proto_on is set, every other word is 16 bits or less
	a_rdata_upper: assert property ($rose(s_axi_rvalid)
		&& $past(s_axi_araddr) != ACP_OFS_ADDRS |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	a_reset_values: assert property ($rose(rst_b) |-> pretrigger_ms == 16'h0064
		&& capture_depth_q == 16'h03E8 && !termination_on)
		else $error("wrong value after reset");
	a_depth_range: assert property (capture_depth_q != 16'h0000 && capture_depth_q <= 16'h9C40)
		else $error("capture depth out of range");
	a_frame_legal: assert property ($past(rst_b) |-> line_cfg.frame <= 3'h5)
		else $error("illegal framing group");
endmodule

bind acp_top acp_properties u_acp_properties (.ref_clk(ref_clk), .rst_b(rst_b),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_araddr(s_axi_araddr),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.termination_on(termination_on), .line_cfg(line_cfg), .pretrigger_ms(pretrigger_ms),
	.capture_depth_q(capture_depth_q));

/* bench/acp_sample_src.sv */
/*
 stand-in for the measurement core feeding the mean buffer.
 assumes go is a one-cycle request from the bench.
*/
`timescale 1ns/10ps
module acp_sample_src (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic go,
	input wire logic [15:0] val,
	output logic sample_valid,
	output logic [15:0] sample
);
	// idle value toggles so a stale sample is never taken for a new one
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			sample_valid <= 1'b0;
			sample <= 16'h0000;
		end else begin
			sample_valid <= go;
			sample <= go ? val : ~sample;
		end
	end
endmodule

/* bench/acp_top_bench.sv */
/*
 self-checking bench for acp_top: registers over the bus, decoded outputs.
 assumes the checker is bound from its own file.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module acp_top_bench
	import acp_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic go = 1'b0, proto = 1'b0;
	logic [15:0] gval = 16'h0000, v;
	logic awready, wready, bvalid, arready, rvalid, svalid, term;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] sval, per, pre, dep;
	acp_line_t line;
	logic [22:0] el;
	logic [31:0] rnd = 32'hAA651E4E;
	int n_mismatch = 0;
	int checks = 0;
	logic [19:0] bauds [0:10] = '{20'h004B0, 20'h00960, 20'h012C0, 20'h02580, 20'h04B00,
		20'h09600, 20'h0E100, 20'h1C200, 20'h38400, 20'h70800, 20'hE1000};
	logic [35:0] adt [0:5] = '{36'h011001022, 36'h400410420, 36'h202201211, 36'h011001021,
		36'h081082083, 36'h001002003};

	acp_top u_acp_top (.ref_clk(ref_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sample_valid(svalid), .sample(sval), .state_proto_on(proto), .termination_on(term),
		.line_cfg(line), .mean_period(per), .pretrigger_ms(pre), .capture_depth_q(dep));
	acp_sample_src u_acp_sample_src (.ref_clk(ref_clk), .rst_b(rst_b), .go(go), .val(gval),
		.sample_valid(svalid), .sample(sval));

	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [15:0] per_of(input logic [15:0] c, input logic [15:0] oi);
		case (c)
			16'h0000: return oi / 16'h0064;
			16'h0001: return 16'h000A;
			16'h0002: return 16'h0064;
			16'h0003: return 16'h0258;
			16'h0004: return 16'h04B0;
			16'h0005: return 16'h1770;
			default: return c;
		endcase
	endfunction

	task automatic wrc(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
		logic ta, tw, tv, tb;
		logic [1:0] r;
		tb = 1'b0;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		// ready only once the answer shows, so a held response gets exercised
		for (int i = 0; i < 64 && !tb; i++) begin
			@(negedge ref_clk);
			ta = awready;
			tw = wready;
			tv = bvalid;
			tb = bvalid && bready;
			r = bresp;
			@(posedge ref_clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tv) bready <= !tb;
		end
		`CHK({tb, r}, {1'b1, er})
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic ta, tv, tr;
		logic [31:0] d;
		logic [1:0] r;
		tr = 1'b0;
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		for (int i = 0; i < 64 && !tr; i++) begin
			@(negedge ref_clk);
			ta = arready;
			tv = rvalid;
			tr = rvalid && rready;
			d = rdata;
			r = rresp;
			@(posedge ref_clk);
			if (ta) arvalid <= 1'b0;
			if (tv) rready <= !tr;
		end
		`CHK({tr, r}, {1'b1, er})
		if (er === 2'h0) `CHK(d, e)
	endtask

	task automatic done(input string n);
		$display("test %s ended, mismatches %0d", n, n_mismatch);
	endtask

	task final_report;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge ref_clk);
		el = {bauds[3], 3'h0};
		`CHK(line, el)
		rdc(8'h00, 32'h0000000A, 2'h0);
		rdc(8'h18, 32'h00000064, 2'h0);
		rdc(8'h20, 32'h000003E8, 2'h0);
		rdc(8'h24, 32'h00000000, 2'h0);
		rdc(8'h14, {16'h0000, ACP_LOADER_VER}, 2'h0);
		rdc(8'h80, 32'h00000000, 2'h2);
		rnd = lfsr(rnd);
		@(posedge ref_clk);
		go <= 1'b1;
		gval <= rnd[15:0];
		@(posedge ref_clk);
		go <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rdc(8'h3C, {16'h0000, rnd[15:0]}, 2'h0);
		rdc(8'h2C, 32'h00000020, 2'h0);
		done("reset and start");
		wrc(8'h04, 16'h09C4, 2'h0);
		for (int c = 0; c < 6; c++) begin
			wrc(8'h00, 16'(c), 2'h0);
			rdc(8'h34, {16'h0000, per_of(16'(c), 16'h09C4)}, 2'h0);
			`CHK(per, per_of(16'(c), 16'h09C4))
		end
		rnd = lfsr(rnd);
		v = 16'h0006 + rnd[15:0] % 16'hEA5B;
		wrc(8'h00, v, 2'h0);
		rdc(8'h34, {16'h0000, v}, 2'h0);
		wrc(8'h00, 16'hEA60, 2'h0);
		wrc(8'h00, 16'hEA61, 2'h2);
		rdc(8'h00, 32'h0000EA60, 2'h0);
		done("averaging");
		for (int k = 0; k < 2; k++) begin
			rnd = lfsr(rnd);
			v = 16'h7530 + (rnd[15:0] % 16'h0DE1) * 16'h000A;
			wrc(8'h08 + 8'(k * 4), v, 2'h0);
			rdc(8'h08 + 8'(k * 4), {16'h0000, v}, 2'h0);
		end
		rdc(8'h30, 32'h00000000, 2'h0);
		proto <= 1'b1;
		for (int s = 0; s < 6; s++) begin
			wrc(8'h10, 16'(s), 2'h0);
			rdc(8'h30, {adt[s][7:0], adt[s][23:12], adt[s][35:24]}, 2'h0);
		end
		wrc(8'h10, 16'h0006, 2'h2);
		done("scales and addresses");
		for (int c = 2; c < 50; c++) begin
			wrc(8'h1C, 16'(c), 2'h0);
			repeat (2) @(posedge ref_clk);
			el = {bauds[(c - 2) % 8], 3'((c - 2) / 8)};
			`CHK(line, el)
			rdc(8'h28, 32'(c), 2'h0);
		end
		wrc(8'h1C, 16'h0032, 2'h2);
		wrc(8'h1C, 16'h0001, 2'h2);
		`CHK(line, el)
		wrc(8'h1C, 16'h0005, 2'h0);
		wrc(8'h28, 16'h0065, 2'h2);
		for (int c = 101; c < 104; c++) begin
			wrc(8'h40, 16'h0001, 2'h0);
			wrc(8'h28, 16'(c), 2'h0);
			repeat (2) @(posedge ref_clk);
			el = {bauds[c - 93], 3'h0};
			`CHK(line, el)
			rdc(8'h1C, 32'(c), 2'h0);
			rdc(8'h38, 32'h00000005, 2'h0);
			wrc(8'h44, 16'h0001, 2'h0);
			repeat (2) @(posedge ref_clk);
			el = {bauds[3], 3'h0};
			`CHK(line, el)
		end
		wrc(8'h40, 16'h0001, 2'h0);
		wrc(8'h28, 16'h0067, 2'h0);
		wrc(8'h28, 16'h0067, 2'h0);
		rdc(8'h38, 32'h00000067, 2'h0);
		wrc(8'h44, 16'h0001, 2'h0);
		repeat (2) @(posedge ref_clk);
		el = {bauds[10], 3'h0};
		`CHK(line, el)
		wrc(8'h28, 16'h0068, 2'h2);
		done("line rates");
		wrc(8'h20, 16'h0000, 2'h2);
		wrc(8'h20, 16'h9C40, 2'h0);
		wrc(8'h20, 16'h9C41, 2'h2);
		`CHK(dep, 16'h9C40)
		rnd = lfsr(rnd);
		wrc(8'h18, rnd[15:0], 2'h0);
		`CHK(pre, rnd[15:0])
		wrc(8'h24, 16'h0001, 2'h0);
		`CHK(term, 1'b1)
		wrc(8'h24, 16'h0002, 2'h2);
		wrc(8'h24, 16'h0000, 2'h0);
		`CHK(term, 1'b0)
		done("burst and termination");
		final_report;
	end

	// far above the nine hundred or so cycles the tests need
	initial begin
		#100000;
		n_mismatch++;
		final_report;
	end
endmodule
